// [inc/dtc_pkg.sv]
// Purpose: Shared constants and types of the dual timer/counter block
// Assumes: Register indices are word indices; byte address is four times
// Notes: Mode register layout follows the timer mode control byte

package dtc_pkg;

  // ---------------------------------------------------------------
  // Register indices (byte address = 4 * index)
  // ---------------------------------------------------------------
  localparam logic [9:0] DTC_IDX_MODE = 10'h089;
  localparam logic [9:0] DTC_IDX_RUN = 10'h080;
  localparam logic [9:0] DTC_IDX_STATUS = 10'h081;
  localparam logic [9:0] DTC_IDX_MASK = 10'h082;
  localparam logic [9:0] DTC_IDX_U0_LOW = 10'h083;
  localparam logic [9:0] DTC_IDX_U0_HIGH = 10'h084;
  localparam logic [9:0] DTC_IDX_U1_LOW = 10'h085;
  localparam logic [9:0] DTC_IDX_U1_HIGH = 10'h086;

  // ---------------------------------------------------------------
  // Mode register fields and reset values
  // ---------------------------------------------------------------
  localparam int DTC_U1_GATE_BIT = 7;
  localparam int DTC_U1_SRC_BIT = 6;
  localparam int DTC_U1_MODE_LSB = 4;
  localparam int DTC_U0_GATE_BIT = 3;
  localparam int DTC_U0_SRC_BIT = 2;
  localparam int DTC_U0_MODE_LSB = 0;
  localparam logic [7:0] DTC_MODE_RST = 8'h00;
  localparam logic [1:0] DTC_RUN_RST = 2'h0;
  localparam logic [1:0] DTC_MASK_RST = 2'h0;
  localparam logic [7:0] DTC_CNT_RST = 8'h00;

  // ---------------------------------------------------------------
  // Timing: oscillator periods (pclk cycles) per machine cycle
  // ---------------------------------------------------------------
  localparam int DTC_OSC_PER_MC = 6;
  localparam logic [2:0] DTC_MC_LAST = 3'(DTC_OSC_PER_MC - 1);

  typedef enum logic [1:0] {
    DTC_M13,
    DTC_M16,
    DTC_M8_RELOAD,
    DTC_SPLIT
  } dtc_mode_t;

  typedef struct packed {
    logic [7:0] lo;
    logic [7:0] hi;
    logic ovf;
  } dtc_unit_t;

  typedef struct packed {
    logic [7:0] mode;
    logic [1:0] run;
    logic [1:0] flags;
    logic [1:0] mask;
    logic [1:0][7:0] lo;
    logic [1:0][7:0] hi;
    logic [2:0] presc;
    logic [1:0] smp;
    logic [1:0] pend;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
  } dtc_state_t;

endpackage

// [verification/dtc_pins.sv]
// Purpose: Far-side model of the count and gate pins
// Assumes: Pins change just after rising pclk edges
// Notes: Hold sets pulse speed; 6 is the fastest legal rate

`timescale 1ns/1ps

module dtc_pins
  import dtc_pkg::*;
(
  input wire logic pclk,
  output logic [1:0] count_pin,
  output logic [1:0] gate_pin
);

  initial begin
    count_pin = 2'b11;
    gate_pin = 2'b00;
  end

  // ----------------------------------------
  // Pin sequences
  // ----------------------------------------
  // each level held hold clocks
  task automatic pulses(input int u, input int n, input int hold);
    repeat (n) begin
      @(posedge pclk);
      count_pin[u] <= 1'b0;
      repeat (hold) @(posedge pclk);
      count_pin[u] <= 1'b1;
      repeat (hold - 1) @(posedge pclk);
    end
  endtask

  // gate high for whole machine cycles
  task automatic gate_win(input int u, input int k);
    @(posedge pclk);
    gate_pin[u] <= 1'b1;
    repeat (DTC_OSC_PER_MC * k) @(posedge pclk);
    gate_pin[u] <= 1'b0;
  endtask

endmodule

// [verification/tb_dual_timer_counter.sv]
// Purpose: Self-checking bench of the dual timer block
// Assumes: One pclk; the APB master waits on pready
// Notes: Gate windows of whole machine cycles make tick counts exact

`timescale 1ns/1ps

module tb_dual_timer_counter
  import dtc_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed, rd;
  logic er;
  logic [1:0] count_pin, gate_pin;
  int n_mismatch, comparisons, mfl, n, v;
  int mlo[2], mhi[2];

  dtc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .count_pin(count_pin), .gate_pin(gate_pin), .irq(irq));
  dtc_pins pins (.pclk(pclk), .count_pin(count_pin), .gate_pin(gate_pin));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // ----------------------------------------
  // Checks and bus tasks
  // ----------------------------------------
  task automatic results();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chkb(input logic g, input logic e);
    chk({31'h0, g}, {31'h0, e});
  endtask

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Request held until pready is seen; idle edge after each transfer
  task automatic apb(input logic w, input logic [9:0] i,
      input logic [31:0] d, output logic [31:0] q, output logic e);
    int t;
    t = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 64);
    if (t >= 64) begin
      n_mismatch++;
      results();
    end else begin
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask

  task automatic wr(input logic [9:0] i, input int d);
    apb(1'b1, i, 32'(d), rd, er);
  endtask

  task automatic rc(input logic [9:0] i, input int e);
    apb(1'b0, i, '0, rd, er);
    chk(rd, 32'(e));
  endtask

  // ----------------------------------------
  // Reference model
  // ----------------------------------------
  task automatic step(input int u, input int md);
    int t, w;
    case (md)
      0: begin
        t = ((mhi[u] << 5) | (mlo[u] & 31)) + 1;
        mlo[u] = (mlo[u] & 'he0) | (t & 31);
        mhi[u] = (t >> 5) & 255;
        w = t >> 13;
      end
      1: begin
        t = ((mhi[u] << 8) | mlo[u]) + 1;
        mlo[u] = t & 255;
        mhi[u] = (t >> 8) & 255;
        w = t >> 16;
      end
      default: begin
        t = mlo[u] + 1;
        w = t >> 8;
        mlo[u] = (w != 0 && md == 2) ? mhi[u] : t & 255;
      end
    endcase
    mfl = mfl | (w << u);
  endtask

  task automatic load(input int u, input int l, input int h);
    wr(10'(DTC_IDX_U0_LOW + 2 * u), l);
    wr(10'(DTC_IDX_U0_HIGH + 2 * u), h);
    mlo[u] = l;
    mhi[u] = h;
  endtask

  task automatic gtim(input int u, input int k, input int md);
    pins.gate_win(u, k);
    repeat (k) step(u, md);
  endtask

  task automatic rstat();
    rc(DTC_IDX_STATUS, mfl);
    mfl = 0;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (100000) @(posedge pclk);
    n_mismatch++;
    results();
  end

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    presetn = 1'b0;
    seed = 32'h0001_08a5;
    n_mismatch = 0;
    comparisons = 0;
    mfl = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 7; i++) rc(10'(DTC_IDX_RUN + i), 0);
    rc(DTC_IDX_MODE, int'(DTC_MODE_RST));
    apb(1'b0, 10'h08f, '0, rd, er);
    chkb(er, 1'b1);
    // Mode one, unit 0 gated timer
    wr(DTC_IDX_MASK, 1);
    wr(DTC_IDX_MODE, 'h09);
    load(0, 'hfe, 'hff);
    wr(DTC_IDX_RUN, 1);
    rc(DTC_IDX_U0_LOW, mlo[0]);
    gtim(0, 3, 1);
    rc(DTC_IDX_U0_LOW, mlo[0]);
    rc(DTC_IDX_U0_HIGH, mhi[0]);
    chkb(irq, 1'b1);
    rstat();
    chkb(irq, 1'b0);
    // Mode zero carries out of low five bits
    wr(DTC_IDX_MODE, 'h08);
    load(0, 'hff, 'h00);
    gtim(0, 1, 0);
    apb(1'b0, DTC_IDX_U0_LOW, '0, rd, er);
    chk(rd & 32'h0000_001f, 32'(mlo[0] & 'h1f));
    rc(DTC_IDX_U0_HIGH, mhi[0]);
    // Mode two reload
    wr(DTC_IDX_MODE, 'h0a);
    load(0, 'hff, 'h80);
    gtim(0, 2, 2);
    rc(DTC_IDX_U0_LOW, mlo[0]);
    rc(DTC_IDX_U0_HIGH, mhi[0]);
    rstat();
    // Split unit 0, unit 1 parked in split mode
    wr(DTC_IDX_RUN, 0);
    wr(DTC_IDX_MODE, 'h3b);
    load(0, 'hfe, 'hff);
    load(1, 'h55, 'h00);
    wr(DTC_IDX_RUN, 3);
    gtim(0, 2, 3);
    wr(DTC_IDX_RUN, 0);
    mfl = mfl | 2;
    rc(DTC_IDX_U0_LOW, mlo[0]);
    rstat();
    rc(DTC_IDX_U1_LOW, 'h55);
    // Unit 1 counts pin edges, fast then slow
    wr(DTC_IDX_MODE, 'h50);
    v = int'(xs() & 32'h0000_007f);
    n = 1 + int'(xs() % 8);
    load(1, v, 0);
    wr(DTC_IDX_RUN, 2);
    pins.pulses(1, n, DTC_OSC_PER_MC);
    pins.pulses(1, 3, 9);
    repeat (n + 3) step(1, 1);
    repeat (18) @(posedge pclk);
    rc(DTC_IDX_U1_LOW, mlo[1]);
    rc(DTC_IDX_U1_HIGH, mhi[1]);
    // Unit 1 gated mode two timer, unit 0 counts pin edges
    wr(DTC_IDX_MASK, 3);
    wr(DTC_IDX_MODE, 'ha5);
    load(0, 'h10, 0);
    load(1, 'hfe, 'h40);
    wr(DTC_IDX_RUN, 3);
    pins.pulses(0, 2, DTC_OSC_PER_MC);
    repeat (2) step(0, 1);
    gtim(1, 3, 2);
    rc(DTC_IDX_U0_LOW, mlo[0]);
    rc(DTC_IDX_U1_LOW, mlo[1]);
    rc(DTC_IDX_U1_HIGH, mhi[1]);
    chkb(irq, 1'b1);
    rstat();
    chkb(irq, 1'b0);
    results();
  end

endmodule

// [verilog/dtc_top.sv]
// Purpose: Two 16-bit timer/counter units behind an APB register slave
// Assumes: pclk is the oscillator; count and gate pins are synchronous
// Notes: One wait state on every APB access; status clears on read
//
// What this block does
// - Timer function increments once per machine cycle of six clocks.
// - Counter function counts falling count-pin edges, sampled once per cycle.
// - Edge is high sample then low; count shows one machine cycle later.
// - Edge recognition takes two machine cycles; one count per twelve clocks.
// - Source select bits 6 and 2 pick internal or pin counting.
// - Mode fields bits 5:4 and 1:0 pick one of four modes.
// - Gate set needs gate pin high plus run bit; else run alone.
// - Modes zero to two count alike in both units; unit 0 split takes unit 1's flag.
// - Unit 0 split: low byte uses all unit 0 controls.
// - Unit 0 split: high byte times machine cycles on unit 1 run.
// - Mode zero is 13 bits; upper three low bits ignored.
// - Mode one cascades all sixteen bits, no prescaler.
// - Mode two low byte reloads from high byte on overflow.
// - Unit 1 in split mode stops and holds its count.
//
// Decided for this implementation: the APB register port.

`timescale 1ns/1ps

module dtc_top
  import dtc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] count_pin,
  input wire logic [1:0] gate_pin,
  output logic irq
);

  // -----------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------
  function automatic logic dtc_hit(input logic [9:0] idx);
    dtc_hit = (idx == DTC_IDX_MODE) || (idx == DTC_IDX_RUN) ||
              (idx == DTC_IDX_STATUS) || (idx == DTC_IDX_MASK) ||
              (idx == DTC_IDX_U0_LOW) || (idx == DTC_IDX_U0_HIGH) ||
              (idx == DTC_IDX_U1_LOW) || (idx == DTC_IDX_U1_HIGH);
  endfunction

  // One counting step of a unit in modes zero to two
  function automatic dtc_unit_t dtc_step(input logic [1:0] m,
                                         input logic [7:0] lo,
                                         input logic [7:0] hi,
                                         input logic inc);
    dtc_unit_t r;
    logic [5:0] l5;
    logic [8:0] n9;
    logic [16:0] w;
    r.lo = lo;
    r.hi = hi;
    r.ovf = 1'b0;
    l5 = 6'h00;
    n9 = 9'h000;
    w = 17'h0_0000;
    if (inc) begin
      case (dtc_mode_t'(m))
        DTC_M13: begin
          l5 = {1'b0, lo[4:0]} + 6'h01;
          r.lo[4:0] = l5[4:0];
          if (l5[5]) begin
            n9 = {1'b0, hi} + 9'h001;
            r.hi = n9[7:0];
            r.ovf = n9[8];
          end
        end
        DTC_M16: begin
          w = {1'b0, hi, lo} + 17'h0_0001;
          {r.ovf, r.hi, r.lo} = w;
        end
        DTC_M8_RELOAD: begin
          n9 = {1'b0, lo} + 9'h001;
          r.ovf = n9[8];
          r.lo = n9[8] ? hi : n9[7:0];
        end
        default: begin
          r.ovf = 1'b0;
        end
      endcase
    end
    return r;
  endfunction

  // -----------------------------------------------------------------
  // State
  // -----------------------------------------------------------------
  dtc_state_t q;
  dtc_state_t d;
  logic tick;
  logic access;
  logic finish;
  logic bus_wr;
  logic [9:0] idx;
  logic [1:0] en;
  logic [1:0] inc;
  logic [1:0] src;
  logic [1:0] gate;
  logic [1:0][1:0] mode;
  logic [1:0] set;
  logic [1:0] clr;
  logic [8:0] th0;
  logic [8:0] tl0;
  dtc_unit_t u0;
  dtc_unit_t u1;

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign irq = q.irq;

  always_comb begin
    d = q;
    idx = paddr[11:2];
    access = psel && penable;
    finish = access && q.pready;
    bus_wr = finish && pwrite;

    // -----------------------------------------------------------------
    // Machine cycle prescaler
    // -----------------------------------------------------------------
    // six clocks a machine cycle
    tick = (q.presc == DTC_MC_LAST);
    d.presc = tick ? 3'h0 : q.presc + 3'h1;

    // -----------------------------------------------------------------
    // Control decode
    // -----------------------------------------------------------------
    // source select bits
    src[0] = q.mode[DTC_U0_SRC_BIT];
    src[1] = q.mode[DTC_U1_SRC_BIT];
    gate[0] = q.mode[DTC_U0_GATE_BIT];
    gate[1] = q.mode[DTC_U1_GATE_BIT];
    mode[0] = q.mode[DTC_U0_MODE_LSB +: 2];
    mode[1] = q.mode[DTC_U1_MODE_LSB +: 2];

    for (int i = 0; i < 2; i++) begin
      en[i] = q.run[i] && (!gate[i] || gate_pin[i]);
      // high then low marks an edge
      if (tick) begin
        d.smp[i] = count_pin[i];
        d.pend[i] = q.smp[i] && !count_pin[i];
      end
      // count lands on the following tick
      // pend cannot repeat on adjacent ticks
      inc[i] = tick && en[i] && (src[i] ? q.pend[i] : 1'b1);
    end

    // -----------------------------------------------------------------
    // Counting
    // -----------------------------------------------------------------
    // same step function for both units
    u0 = dtc_step(mode[0], q.lo[0], q.hi[0], inc[0]);
    // split mode on unit 1 holds the count
    u1 = dtc_step(mode[1], q.lo[1], q.hi[1], inc[1]);
    tl0 = 9'h000;
    th0 = 9'h000;
    set = 2'h0;
    if (dtc_mode_t'(mode[0]) == DTC_SPLIT) begin
      // low byte on unit 0 controls
      tl0 = {1'b0, q.lo[0]} + 9'h001;
      if (inc[0]) begin
        d.lo[0] = tl0[7:0];
      end
      // high byte timer on unit 1 run
      th0 = {1'b0, q.hi[0]} + 9'h001;
      if (tick && q.run[1]) begin
        d.hi[0] = th0[7:0];
      end
      // split high byte owns unit 1 flag
      set[0] = inc[0] && tl0[8];
      set[1] = tick && q.run[1] && th0[8];
      d.lo[1] = u1.lo;
      d.hi[1] = u1.hi;
    end else begin
      d.lo[0] = u0.lo;
      d.hi[0] = u0.hi;
      d.lo[1] = u1.lo;
      d.hi[1] = u1.hi;
      set = {u1.ovf, u0.ovf};
    end

    // -----------------------------------------------------------------
    // APB slave, one wait state
    // -----------------------------------------------------------------
    d.pready = access && !q.pready;
    d.pslverr = access && !q.pready && !dtc_hit(idx);
    if (access && !q.pready) begin
      case (idx)
        DTC_IDX_MODE: d.prdata = {24'h00_0000, q.mode};
        DTC_IDX_RUN: d.prdata = {30'h0000_0000, q.run};
        DTC_IDX_STATUS: d.prdata = {30'h0000_0000, q.flags};
        DTC_IDX_MASK: d.prdata = {30'h0000_0000, q.mask};
        DTC_IDX_U0_LOW: d.prdata = {24'h00_0000, q.lo[0]};
        DTC_IDX_U0_HIGH: d.prdata = {24'h00_0000, q.hi[0]};
        DTC_IDX_U1_LOW: d.prdata = {24'h00_0000, q.lo[1]};
        DTC_IDX_U1_HIGH: d.prdata = {24'h00_0000, q.hi[1]};
        default: d.prdata = 32'h0000_0000;
      endcase
    end

    // Read of status clears; a set in the same cycle still wins
    // Clear only reported flags, so a set after capture is kept
    clr = (finish && !pwrite && idx == DTC_IDX_STATUS) ?
          q.prdata[1:0] : 2'h0;
    d.flags = (q.flags & ~clr) | set;

    // software writes win over a count in the same cycle
    if (bus_wr) begin
      case (idx)
        DTC_IDX_MODE: d.mode = pwdata[7:0];
        // run bit does not touch counts
        DTC_IDX_RUN: d.run = pwdata[1:0];
        DTC_IDX_MASK: d.mask = pwdata[1:0];
        DTC_IDX_U0_LOW: d.lo[0] = pwdata[7:0];
        DTC_IDX_U0_HIGH: d.hi[0] = pwdata[7:0];
        DTC_IDX_U1_LOW: d.lo[1] = pwdata[7:0];
        DTC_IDX_U1_HIGH: d.hi[1] = pwdata[7:0];
        default: d.mask = q.mask;
      endcase
    end

    // Level interrupt follows the next flag state so it never lags
    d.irq = |(d.flags & d.mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.mode <= DTC_MODE_RST;
      q.run <= DTC_RUN_RST;
      q.mask <= DTC_MASK_RST;
      q.lo <= {DTC_CNT_RST, DTC_CNT_RST};
      q.hi <= {DTC_CNT_RST, DTC_CNT_RST};
    end else begin
      q <= d;
    end
  end

  // -----------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------
  default clocking dtc_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic [15:0] cnt0;
  logic [15:0] cnt1;
  assign cnt0 = {q.hi[0], q.lo[0]};
  assign cnt1 = {q.hi[1], q.lo[1]};

  mc_period_a:
    assert property (tick |=> !tick [*5] ##1 tick)
    else $error("machine cycle is not six clocks");

  timer_inc_a:
    assert property (inc[0] && !src[0] && mode[0] == 2'h1 && !bus_wr
                     |=> cnt0 == $past(cnt0) + 16'h0001)
    else $error("16-bit timer did not step by one");

  edge_pend_a:
    assert property (tick && q.smp[1] && !count_pin[1] |=> q.pend[1])
    else $error("falling edge not detected");

  count_late_a:
    assert property (tick && q.pend[1] && src[1] && en[1] &&
                     mode[1] == 2'h1 && !bus_wr
                     |=> cnt1 == $past(cnt1) + 16'h0001)
    else $error("pin edge did not count on next machine cycle");

  count_rate_a:
    assert property ($rose(q.pend[1]) |-> q.pend[1] [*6] ##1 !q.pend[1])
    else $error("edges recognised faster than one per two cycles");

  gate_hold_a:
    assert property (gate[0] && !gate_pin[0] && mode[0] != 2'h3 &&
                     !bus_wr |=> $stable(cnt0))
    else $error("gated unit counted with gate pin low");

  reload_a:
    assert property (inc[1] && mode[1] == 2'h2 && q.lo[1] == 8'hff &&
                     mode[0] != 2'h3 && !bus_wr
                     |=> q.lo[1] == $past(q.hi[1]) && q.flags[1])
    else $error("mode two overflow did not reload and flag");

  split_stop_a:
    assert property (mode[1] == 2'h3 && !bus_wr |=> $stable(cnt1))
    else $error("unit 1 counted in split mode");

  split_high_a:
    assert property (mode[0] == 2'h3 && tick && q.run[1] && !bus_wr
                     |=> q.hi[0] == $past(q.hi[0]) + 8'h01)
    else $error("split high byte did not time on unit 1 run");

  ovf_flag_a:
    assert property (inc[0] && mode[0] == 2'h1 && cnt0 == 16'hffff &&
                     !bus_wr |=> q.flags[0])
    else $error("rollover did not set unit flag");

  irq_level_a:
    assert property ((|(set & q.mask)) && !bus_wr |=> q.irq)
    else $error("unmasked overflow did not raise the interrupt");

  m13_carry_a:
    assert property (inc[0] && mode[0] == 2'h0 && q.lo[0][4:0] == 5'h1f &&
                     !bus_wr |=> q.lo[0][7:5] == $past(q.lo[0][7:5]) &&
                     q.hi[0] == $past(q.hi[0]) + 8'h01)
    else $error("mode zero carry out of five bits failed");

  split_low_a:
    assert property (mode[0] == 2'h3 && inc[0] && !bus_wr
                     |=> q.lo[0] == $past(q.lo[0]) + 8'h01)
    else $error("split low byte did not count on unit 0 controls");

  split_flag_a:
    assert property (mode[0] == 2'h3 && inc[0] && q.lo[0] == 8'hff
                     |=> q.flags[0])
    else $error("split low byte overflow did not set unit 0 flag");

  flag_keep_a:
    assert property (!(finish && !pwrite && idx == DTC_IDX_STATUS)
                     |=> ($past(q.flags) & ~q.flags) == 2'h0)
    else $error("overflow flag dropped without a status read");

  flag_clear_a:
    assert property (finish && !pwrite && idx == DTC_IDX_STATUS |=>
                     ($past(q.flags & ~q.prdata[1:0]) & ~q.flags) == 2'h0 &&
                     (q.flags & $past(q.prdata[1:0] & ~set)) == 2'h0)
    else $error("status read cleared the wrong flags");

endmodule
